// ==== design/pmx_regs.svh ====
// Constants of the port pin multiplexer: reset values, field positions, pin indices.
// Assumes pins are numbered port*8+bit, port A=0, B=1, C=2, D=3.
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH

// Peripheral enable reset value, one byte per port, A in the low byte
`define PMX_PEREN_RST     32'h0FFF0080
// Writable peripheral enable bits; port D has four pins only
`define PMX_PEREN_MASK    32'h0FFFFFFF
// Pins with a package connection; C3 and C7 are internal only
`define PMX_BONDED_MASK   32'h0F77FFFF
`define PMX_SEL_RST       16'h0000

// Peripheral select register fields
`define PMX_SEL_A4_LSB    0
`define PMX_SEL_A5_LSB    2
`define PMX_SEL_B0_BIT    4
`define PMX_SEL_B1_BIT    5
`define PMX_SEL_B2_BIT    6
`define PMX_SEL_B3_BIT    7
`define PMX_SEL_B4_BIT    8
`define PMX_SEL_B5_BIT    9
`define PMX_SEL_B6_BIT    10
`define PMX_SEL_B7_BIT    11

// Flat pin indices
`define PMX_PIN_A4        4
`define PMX_PIN_A5        5
`define PMX_PIN_A6        6
`define PMX_PIN_A7        7
`define PMX_PIN_B0        8
`define PMX_PIN_B1        9
`define PMX_PIN_B2        10
`define PMX_PIN_B3        11
`define PMX_PIN_B4        12
`define PMX_PIN_B5        13
`define PMX_PIN_B6        14
`define PMX_PIN_B7        15
`define PMX_PIN_C0        16
`define PMX_PIN_D0        24
`define PMX_PIN_D1        25
`define PMX_PIN_D2        26
`define PMX_PIN_D3        27

`endif

// ==== design/pmx_pkg.sv ====
// Types of the port pin multiplexer.
// Assumes pmx_regs.svh for numeric constants.
package pmx_pkg;
	typedef logic [31:0] pmx_pins_t;
	// Select codes of the three-way pins A4 and A5
	typedef enum logic [1:0] {
		PMX_A_PWM   = 2'h0,
		PMX_A_FAULT = 2'h1,
		PMX_A_TMR   = 2'h2,
		PMX_A_RSVD  = 2'h3
	} pmx_a_sel_e;
endpackage

// ==== design/pmx_cfg_if.sv ====
// Configuration carrier between the select register store and the pin mux.
// Assumes one clock domain; no timing of its own.
`timescale 1ns/1ps
interface pmx_cfg_if;
	pmx_pkg::pmx_pins_t peren;
	logic [15:0]        sel;
	modport regs (output peren, output sel);
	modport mux  (input peren, input sel);
endinterface

// ==== design/pmx_cfg_regs.sv ====
// Peripheral enable and peripheral select register store.
// Assumes writes arrive as one-cycle strobes synchronous to i_mclk.
`timescale 1ns/1ps
`include "pmx_regs.svh"
module pmx_cfg_regs (
	input  wire logic        i_mclk,
	input  wire logic        i_srst,
	input  wire logic [3:0]  i_peren_we,
	input  wire logic [7:0]  i_peren_wdata,
	input  wire logic        i_sel_we,
	input  wire logic [15:0] i_sel_wdata,
	pmx_cfg_if.regs          cfg
);
	localparam logic [31:0] PEREN_RST  = `PMX_PEREN_RST;
	localparam logic [31:0] PEREN_MASK = `PMX_PEREN_MASK;

	genvar p;
	generate
		for (p = 0; p < 4; p++) begin : g_port
			always_ff @(posedge i_mclk) begin
				if (i_srst) begin
					cfg.peren[p*8 +: 8] <= PEREN_RST[p*8 +: 8];
				end else if (i_peren_we[p]) begin
					cfg.peren[p*8 +: 8] <= i_peren_wdata & PEREN_MASK[p*8 +: 8];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			cfg.sel <= `PMX_SEL_RST;
		end else if (i_sel_we) begin
			cfg.sel <= i_sel_wdata;
		end
	end
endmodule // pmx_cfg_regs

// ==== design/pmx_pin_cell.sv ====
// One pad: chooses GPIO or peripheral drive and samples the pad input.
// Assumes pad input is synchronous to i_mclk.
`timescale 1ns/1ps
module pmx_pin_cell #(
	parameter bit BONDED = 1'b1
) (
	input  wire logic i_mclk,
	input  wire logic i_srst,
	input  wire logic i_gpio_out,
	input  wire logic i_gpio_oe,
	input  wire logic i_per_en,
	input  wire logic i_per_out,
	input  wire logic i_per_oe,
	input  wire logic i_hold_off,
	input  wire logic i_pad_in,
	output logic      o_pad_out,
	output logic      o_pad_oe,
	output logic      o_pad_in_r
);
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_pad_out <= 1'b0;
			o_pad_oe  <= 1'b0;
		end else begin
			o_pad_out <= BONDED & (i_per_en ? i_per_out : i_gpio_out);
			o_pad_oe  <= BONDED & ~i_hold_off & (i_per_en ? i_per_oe : i_gpio_oe);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_pad_in_r <= 1'b0;
		end else begin
			o_pad_in_r <= BONDED & i_pad_in;
		end
	end
endmodule // pmx_pin_cell

// ==== design/pmx_pin_mux.sv ====
// Pin multiplexer of the four general-purpose ports.
// Assumes peripherals and GPIO logic on i_mclk; pins are numbered port*8+bit.
//
// Summary of operation
// - Ports A, B, C and D offer 8, 8, 6 and 4 usable pins.
// - After reset A and B are GPIO except A7 which is the reset pin, C is analog, D is JTAG.
// - Alternate signals on shared pins are chosen by the peripheral select register.
// - Pin A4 carries pulse output four, fault input one or timer channel two, GPIO at reset.
// - Pin A5 carries pulse output five, fault input two or timer channel three, GPIO at reset.
// - Pin B0 carries the SPI clock or the I2C clock, GPIO at reset.
// - Pin B1 carries the SPI slave select or the I2C data line, GPIO at reset.
// - Pin B2 carries SPI master-in data or timer channel two, GPIO at reset.
// - Pin B3 carries SPI master-out data or timer channel three, GPIO at reset.
// - Pin B4 carries timer channel zero or the clock output, GPIO at reset.
// - Pin B5 carries timer channel one or fault input three, GPIO at reset.
// - Pin B6 carries the serial receive input or the I2C data line, GPIO at reset.
// - Pin B6 is the external clock input only while the PLL control enables it.
// - Pin B7 carries the serial transmit output or the I2C clock, GPIO at reset.
// - Pins C3 and C7 have no package connection but keep their internal analog default.
`timescale 1ns/1ps
`include "pmx_regs.svh"
module pmx_pin_mux (
	input  wire logic        i_mclk,
	input  wire logic        i_srst,
	input  wire logic [3:0]  i_peren_we,
	input  wire logic [7:0]  i_peren_wdata,
	input  wire logic        i_sel_we,
	input  wire logic [15:0] i_sel_wdata,
	input  wire logic        i_external_clock_input_en,
	output logic      [31:0] o_peren,
	output logic      [15:0] o_sel,
	input  wire logic [31:0] i_gpio_out,
	input  wire logic [31:0] i_gpio_oe,
	output logic      [31:0] o_gpio_in,
	input  wire logic [31:0] i_pad_in,
	output logic      [31:0] o_pad_out,
	output logic      [31:0] o_pad_oe,
	output logic      [7:0]  o_analog_en,
	input  wire logic [5:0]  i_pwm_out,
	output logic      [3:0]  o_fault_in,
	input  wire logic [3:0]  i_tmr_out,
	input  wire logic [3:0]  i_tmr_oe,
	output logic      [3:0]  o_tmr_in,
	input  wire logic [3:0]  i_spi_out,
	input  wire logic [3:0]  i_spi_oe,
	output logic      [3:0]  o_spi_in,
	input  wire logic        i_scl_low,
	input  wire logic        i_sda_low,
	output logic             o_scl_in,
	output logic             o_sda_in,
	input  wire logic        i_txd,
	output logic             o_rxd,
	input  wire logic        i_clk_out,
	output logic             o_ext_clk,
	output logic             o_reset_pin_n,
	input  wire logic        i_tdo,
	input  wire logic        i_tdo_oe,
	output logic             o_tdi,
	output logic             o_tck,
	output logic             o_tms
);
	localparam logic [31:0] BONDED = `PMX_BONDED_MASK;

	pmx_cfg_if cfg ();

	pmx_pkg::pmx_pins_t   per_out;
	pmx_pkg::pmx_pins_t   per_oe;
	pmx_pkg::pmx_pins_t   hold_off;
	pmx_pkg::pmx_pins_t   pin_in;
	pmx_pkg::pmx_pins_t   en;
	pmx_pkg::pmx_a_sel_e  a4_sel;
	pmx_pkg::pmx_a_sel_e  a5_sel;
	logic                 b0_i2c;
	logic                 b1_i2c;
	logic                 b2_tmr;
	logic                 b3_tmr;
	logic                 b4_clock_output_pin;
	logic                 b5_fault;
	logic                 b6_i2c;
	logic                 b7_i2c;
	logic                 b6_external_clock_input;

	pmx_cfg_regs u_cfg (
		.i_mclk        (i_mclk),
		.i_srst        (i_srst),
		.i_peren_we    (i_peren_we),
		.i_peren_wdata (i_peren_wdata),
		.i_sel_we      (i_sel_we),
		.i_sel_wdata   (i_sel_wdata),
		.cfg           (cfg.regs)
	);

	assign o_peren = cfg.peren;
	assign o_sel   = cfg.sel;
	assign en      = cfg.peren;

	assign a4_sel   = pmx_pkg::pmx_a_sel_e'(cfg.sel[`PMX_SEL_A4_LSB +: 2]);
	assign a5_sel   = pmx_pkg::pmx_a_sel_e'(cfg.sel[`PMX_SEL_A5_LSB +: 2]);
	assign b0_i2c   = cfg.sel[`PMX_SEL_B0_BIT];
	assign b1_i2c   = cfg.sel[`PMX_SEL_B1_BIT];
	assign b2_tmr   = cfg.sel[`PMX_SEL_B2_BIT];
	assign b3_tmr   = cfg.sel[`PMX_SEL_B3_BIT];
	assign b4_clock_output_pin  = cfg.sel[`PMX_SEL_B4_BIT];
	assign b5_fault = cfg.sel[`PMX_SEL_B5_BIT];
	assign b6_i2c   = cfg.sel[`PMX_SEL_B6_BIT];
	assign b7_i2c   = cfg.sel[`PMX_SEL_B7_BIT];

	assign b6_external_clock_input = i_external_clock_input_en;

	// Output side of every pin in peripheral mode
	always_comb begin
		per_out  = '0;
		per_oe   = '0;
		hold_off = '0;

		// Pulse outputs 0..3 on A0..A3, always driven
		per_out[3:0] = i_pwm_out[3:0];
		per_oe[3:0]  = 4'hF;

		unique case (a4_sel)
			pmx_pkg::PMX_A_FAULT: begin
				per_out[`PMX_PIN_A4] = 1'b0;
				per_oe[`PMX_PIN_A4]  = 1'b0;
			end
			pmx_pkg::PMX_A_TMR: begin
				per_out[`PMX_PIN_A4] = i_tmr_out[2];
				per_oe[`PMX_PIN_A4]  = i_tmr_oe[2];
			end
			default: begin
				// Reserved code falls back to the pulse output
				per_out[`PMX_PIN_A4] = i_pwm_out[4];
				per_oe[`PMX_PIN_A4]  = 1'b1;
			end
		endcase

		unique case (a5_sel)
			pmx_pkg::PMX_A_FAULT: begin
				per_out[`PMX_PIN_A5] = 1'b0;
				per_oe[`PMX_PIN_A5]  = 1'b0;
			end
			pmx_pkg::PMX_A_TMR: begin
				per_out[`PMX_PIN_A5] = i_tmr_out[3];
				per_oe[`PMX_PIN_A5]  = i_tmr_oe[3];
			end
			default: begin
				per_out[`PMX_PIN_A5] = i_pwm_out[5];
				per_oe[`PMX_PIN_A5]  = 1'b1;
			end
		endcase

		// A6 fault zero and A7 reset are inputs; per_oe stays low

		// SPI clock or I2C clock
		// I2C is open drain: drive only the low level
		per_out[`PMX_PIN_B0] = b0_i2c ? 1'b0 : i_spi_out[0];
		per_oe[`PMX_PIN_B0]  = b0_i2c ? i_scl_low : i_spi_oe[0];

		per_out[`PMX_PIN_B1] = b1_i2c ? 1'b0 : i_spi_out[1];
		per_oe[`PMX_PIN_B1]  = b1_i2c ? i_sda_low : i_spi_oe[1];

		per_out[`PMX_PIN_B2] = b2_tmr ? i_tmr_out[2] : i_spi_out[2];
		per_oe[`PMX_PIN_B2]  = b2_tmr ? i_tmr_oe[2] : i_spi_oe[2];

		per_out[`PMX_PIN_B3] = b3_tmr ? i_tmr_out[3] : i_spi_out[3];
		per_oe[`PMX_PIN_B3]  = b3_tmr ? i_tmr_oe[3] : i_spi_oe[3];

		per_out[`PMX_PIN_B4] = b4_clock_output_pin ? i_clk_out : i_tmr_out[0];
		per_oe[`PMX_PIN_B4]  = b4_clock_output_pin ? 1'b1 : i_tmr_oe[0];

		per_out[`PMX_PIN_B5] = b5_fault ? 1'b0 : i_tmr_out[1];
		per_oe[`PMX_PIN_B5]  = b5_fault ? 1'b0 : i_tmr_oe[1];

		per_out[`PMX_PIN_B6] = 1'b0;
		per_oe[`PMX_PIN_B6]  = b6_i2c & i_sda_low;
		hold_off[`PMX_PIN_B6] = b6_external_clock_input;

		per_out[`PMX_PIN_B7] = b7_i2c ? 1'b0 : i_txd;
		per_oe[`PMX_PIN_B7]  = b7_i2c ? i_scl_low : 1'b1;

		// analog mode keeps port C undriven
		hold_off[`PMX_PIN_C0 +: 8] = en[`PMX_PIN_C0 +: 8];

		// Only the test data output of port D drives
		per_out[`PMX_PIN_D1] = i_tdo;
		per_oe[`PMX_PIN_D1]  = i_tdo_oe;
	end

	genvar k;
	generate
		for (k = 0; k < 32; k++) begin : g_pin
			pmx_pin_cell #(
				.BONDED (BONDED[k])
			) u_cell (
				.i_mclk     (i_mclk),
				.i_srst     (i_srst),
				.i_gpio_out (i_gpio_out[k]),
				.i_gpio_oe  (i_gpio_oe[k]),
				.i_per_en   (en[k]),
				.i_per_out  (per_out[k]),
				.i_per_oe   (per_oe[k]),
				.i_hold_off (hold_off[k]),
				.i_pad_in   (i_pad_in[k]),
				.o_pad_out  (o_pad_out[k]),
				.o_pad_oe   (o_pad_oe[k]),
				.o_pad_in_r (pin_in[k])
			);
		end
	endgenerate

	assign o_gpio_in = pin_in;

	// analog default kept on unbonded pins
	assign o_analog_en = en[`PMX_PIN_C0 +: 8];

	// Input side; an unselected input sits at its idle level
	// fault and timer inputs from A4
	// fault and timer inputs from A5
	always_comb begin
		o_fault_in    = 4'h0;
		o_fault_in[0] = en[`PMX_PIN_A6] & pin_in[`PMX_PIN_A6];
		o_fault_in[1] = en[`PMX_PIN_A4] & (a4_sel == pmx_pkg::PMX_A_FAULT)
		                & pin_in[`PMX_PIN_A4];
		o_fault_in[2] = en[`PMX_PIN_A5] & (a5_sel == pmx_pkg::PMX_A_FAULT)
		                & pin_in[`PMX_PIN_A5];
		o_fault_in[3] = en[`PMX_PIN_B5] & b5_fault & pin_in[`PMX_PIN_B5];
	end

	// Timer two and three may sit on two pins; port A wins when both are chosen
	always_comb begin
		o_tmr_in    = 4'h0;
		o_tmr_in[0] = en[`PMX_PIN_B4] & ~b4_clock_output_pin & pin_in[`PMX_PIN_B4];
		o_tmr_in[1] = en[`PMX_PIN_B5] & ~b5_fault & pin_in[`PMX_PIN_B5];
		if (en[`PMX_PIN_A4] && a4_sel == pmx_pkg::PMX_A_TMR) begin
			o_tmr_in[2] = pin_in[`PMX_PIN_A4];
		end else begin
			o_tmr_in[2] = en[`PMX_PIN_B2] & b2_tmr & pin_in[`PMX_PIN_B2];
		end
		if (en[`PMX_PIN_A5] && a5_sel == pmx_pkg::PMX_A_TMR) begin
			o_tmr_in[3] = pin_in[`PMX_PIN_A5];
		end else begin
			o_tmr_in[3] = en[`PMX_PIN_B3] & b3_tmr & pin_in[`PMX_PIN_B3];
		end
	end

	// SPI inputs only while SPI is chosen
	always_comb begin
		o_spi_in    = 4'h2;
		if (en[`PMX_PIN_B0] && !b0_i2c) begin
			o_spi_in[0] = pin_in[`PMX_PIN_B0];
		end
		if (en[`PMX_PIN_B1] && !b1_i2c) begin
			o_spi_in[1] = pin_in[`PMX_PIN_B1];
		end
		if (en[`PMX_PIN_B2] && !b2_tmr) begin
			o_spi_in[2] = pin_in[`PMX_PIN_B2];
		end
		if (en[`PMX_PIN_B3] && !b3_tmr) begin
			o_spi_in[3] = pin_in[`PMX_PIN_B3];
		end
	end

	// I2C lines are wired-AND across their pins
	always_comb begin
		o_scl_in = 1'b1;
		o_sda_in = 1'b1;
		if (en[`PMX_PIN_B0] && b0_i2c) begin
			o_scl_in = o_scl_in & pin_in[`PMX_PIN_B0];
		end
		if (en[`PMX_PIN_B7] && b7_i2c) begin
			o_scl_in = o_scl_in & pin_in[`PMX_PIN_B7];
		end
		if (en[`PMX_PIN_B1] && b1_i2c) begin
			o_sda_in = o_sda_in & pin_in[`PMX_PIN_B1];
		end
		if (en[`PMX_PIN_B6] && b6_i2c && !b6_external_clock_input) begin
			o_sda_in = o_sda_in & pin_in[`PMX_PIN_B6];
		end
	end

	assign o_rxd = (en[`PMX_PIN_B6] && !b6_i2c && !b6_external_clock_input) ? pin_in[`PMX_PIN_B6] : 1'b1;

	assign o_ext_clk = b6_external_clock_input & pin_in[`PMX_PIN_B6];

	// reset pin by default; released reads high
	assign o_reset_pin_n = en[`PMX_PIN_A7] ? pin_in[`PMX_PIN_A7] : 1'b1;

	assign o_tdi = en[`PMX_PIN_D0] ? pin_in[`PMX_PIN_D0] : 1'b1;
	assign o_tck = en[`PMX_PIN_D2] ? pin_in[`PMX_PIN_D2] : 1'b0;
	assign o_tms = en[`PMX_PIN_D3] ? pin_in[`PMX_PIN_D3] : 1'b1;
endmodule // pmx_pin_mux

// ==== test/pmx_pin_mux_assertions.sv ====
// Port-level checks of the pin multiplexer.
// Assumes one i_mclk domain and synchronous active-high i_srst.
`timescale 1ns/1ps
module pmx_pin_mux_chk (
	input wire logic        i_mclk,
	input wire logic        i_srst,
	input wire logic [3:0]  i_peren_we,
	input wire logic [7:0]  i_peren_wdata,
	input wire logic        i_sel_we,
	input wire logic [15:0] i_sel_wdata,
	input wire logic        i_external_clock_input_en,
	input wire logic [31:0] o_peren,
	input wire logic [15:0] o_sel,
	input wire logic [31:0] i_gpio_out,
	input wire logic [31:0] i_gpio_oe,
	input wire logic [31:0] o_gpio_in,
	input wire logic [31:0] i_pad_in,
	input wire logic [31:0] o_pad_out,
	input wire logic [31:0] o_pad_oe,
	input wire logic [5:0]  i_pwm_out,
	input wire logic [3:0]  o_fault_in,
	input wire logic [3:0]  i_tmr_out,
	input wire logic [3:0]  i_tmr_oe,
	input wire logic        i_clk_out
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);

	property p_rst;
		$fell(i_srst) |-> o_peren == 32'h0FFF0080 && o_sel == 16'h0000 && o_pad_oe == 32'h0;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset defaults wrong");
	property p_sel; i_sel_we |=> o_sel == $past(i_sel_wdata); endproperty
	a_sel: assert property (p_sel)
		else $error("select register not loaded");
	property p_peren; i_peren_we[1] |=> o_peren[15:8] == $past(i_peren_wdata); endproperty
	a_peren: assert property (p_peren)
		else $error("port B enable not loaded");
	property p_unbond;
		o_pad_oe[19] == 1'b0 && o_pad_oe[23] == 1'b0
			&& o_gpio_in[19] == 1'b0 && o_gpio_in[23] == 1'b0;
	endproperty
	a_unbond: assert property (p_unbond)
		else $error("unbonded pin active");
	property p_dwidth; o_pad_oe[31:28] == 4'h0 && o_gpio_in[31:28] == 4'h0; endproperty
	a_dwidth: assert property (p_dwidth)
		else $error("missing port D pin active");
	property p_gpio;
		!o_peren[9] |=> o_pad_out[9] == $past(i_gpio_out[9]) && o_pad_oe[9] == $past(i_gpio_oe[9]);
	endproperty
	a_gpio: assert property (p_gpio)
		else $error("GPIO drive not passed");
	property p_a4pwm;
		o_peren[4] && o_sel[1:0] == 2'h0 |=> o_pad_oe[4] && o_pad_out[4] == $past(i_pwm_out[4]);
	endproperty
	a_a4pwm: assert property (p_a4pwm)
		else $error("pulse four not on A4");
	property p_a4flt;
		o_peren[4] && o_sel[1:0] == 2'h1 |-> o_fault_in[1] == $past(i_pad_in[4]);
	endproperty
	a_a4flt: assert property (p_a4flt)
		else $error("fault one not from A4");
	property p_a5tmr;
		o_peren[5] && o_sel[3:2] == 2'h2 |=> o_pad_oe[5] == $past(i_tmr_oe[3])
			&& (!o_pad_oe[5] || o_pad_out[5] == $past(i_tmr_out[3]));
	endproperty
	a_a5tmr: assert property (p_a5tmr)
		else $error("timer three not on A5");
	property p_b4clk; o_peren[12] && o_sel[8] |=> o_pad_out[12] == $past(i_clk_out); endproperty
	a_b4clk: assert property (p_b4clk)
		else $error("clock output not on B4");
	property p_external_clock_input; i_external_clock_input_en |=> !o_pad_oe[14]; endproperty
	a_external_clock_input: assert property (p_external_clock_input)
		else $error("B6 driven as clock input");
	c_flt: cover property (o_peren[4] && o_sel[1:0] == 2'h1);
	c_external_clock_input: cover property (i_external_clock_input_en && o_peren[14]);
	c_i2c: cover property (o_peren[15] && o_sel[11]);
endmodule // pmx_pin_mux_chk

bind pmx_pin_mux pmx_pin_mux_chk u_chk (.i_mclk, .i_srst, .i_peren_we, .i_peren_wdata,
	.i_sel_we, .i_sel_wdata, .i_external_clock_input_en, .o_peren, .o_sel, .i_gpio_out, .i_gpio_oe,
	.o_gpio_in, .i_pad_in, .o_pad_out, .o_pad_oe, .i_pwm_out, .o_fault_in, .i_tmr_out,
	.i_tmr_oe, .i_clk_out);

// ==== test/pmx_periph_model.sv ====
// Peripherals and board seen from the pin multiplexer.
// Assumes changes 1 ns after each rising edge of i_mclk.
`timescale 1ns/1ps
module pmx_periph_model (
	input  wire logic        i_mclk,
	input  wire logic [31:0] i_pad_out,
	input  wire logic [31:0] i_pad_oe,
	output logic      [31:0] o_pad_in,
	output logic      [5:0]  o_pwm_out,
	output logic      [3:0]  o_tmr_out,
	output logic      [3:0]  o_tmr_oe,
	output logic      [3:0]  o_spi_out,
	output logic      [3:0]  o_spi_oe,
	output logic             o_scl_low,
	output logic             o_sda_low,
	output logic             o_txd,
	output logic             o_clk_out,
	output logic             o_tdo,
	output logic             o_tdo_oe
);
	logic [31:0] ext_r;
	task automatic draw;
		ext_r = $urandom;
		o_pad_in = (i_pad_oe & i_pad_out) | (~i_pad_oe & ext_r);
		{o_pwm_out, o_tmr_out, o_tmr_oe, o_spi_out, o_spi_oe} = 22'($urandom);
		{o_scl_low, o_sda_low, o_txd, o_clk_out, o_tdo, o_tdo_oe} = 6'($urandom);
	endtask
	initial begin
		draw();
		o_pad_in = ext_r;
	end
	// Undriven pads see a board value drawn afresh at random 1 ns after every rising edge
	always @(posedge i_mclk) begin
		#1;
		draw();
	end
endmodule // pmx_periph_model

// ==== test/testbench.sv ====
// Self-checking bench of the pin multiplexer with random traffic.
// Assumes pmx_periph_model as far side and the checker bound to the top.
`timescale 1ns/1ps
`include "pmx_regs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); err_count++; end end
module testbench;
	localparam logic [31:0] BOND = `PMX_BONDED_MASK;
	logic        i_mclk = 1'b0;
	logic        i_srst = 1'b1;
	logic        i_sel_we = 1'b0;
	logic        i_external_clock_input_en = 1'b0;
	logic [3:0]  i_peren_we = 4'h0;
	logic [7:0]  i_peren_wdata = 8'h00;
	logic [15:0] i_sel_wdata = 16'h0000;
	logic [31:0] i_gpio_out = 32'h0;
	logic [31:0] i_gpio_oe = 32'h0;
	logic [31:0] i_pad_in, o_peren, o_gpio_in, o_pad_out, o_pad_oe, en_m, eoe, eout, ein;
	logic [15:0] o_sel, sel_m;
	logic [18:0] ei;
	logic [7:0]  o_analog_en;
	logic [5:0]  i_pwm_out;
	logic [3:0]  o_fault_in, i_tmr_out, i_tmr_oe, o_tmr_in, i_spi_out, i_spi_oe, o_spi_in;
	logic        i_scl_low, i_sda_low, o_scl_in, o_sda_in, i_txd, o_rxd, i_clk_out, eclk;
	logic        o_ext_clk, o_reset_pin_n, i_tdo, i_tdo_oe, o_tdi, o_tck, o_tms;
	int          err_count = 0;
	int          num_checks = 0;
	int          cyc = 0;

	always #20 i_mclk = ~i_mclk;

	pmx_pin_mux DUT (.i_mclk, .i_srst, .i_peren_we, .i_peren_wdata, .i_sel_we, .i_sel_wdata,
		.i_external_clock_input_en, .o_peren, .o_sel, .i_gpio_out, .i_gpio_oe, .o_gpio_in, .i_pad_in,
		.o_pad_out, .o_pad_oe, .o_analog_en, .i_pwm_out, .o_fault_in, .i_tmr_out, .i_tmr_oe,
		.o_tmr_in, .i_spi_out, .i_spi_oe, .o_spi_in, .i_scl_low, .i_sda_low, .o_scl_in,
		.o_sda_in, .i_txd, .o_rxd, .i_clk_out, .o_ext_clk, .o_reset_pin_n, .i_tdo, .i_tdo_oe,
		.o_tdi, .o_tck, .o_tms);

	pmx_periph_model u_far (.i_mclk, .i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe),
		.o_pad_in(i_pad_in), .o_pwm_out(i_pwm_out), .o_tmr_out(i_tmr_out),
		.o_tmr_oe(i_tmr_oe), .o_spi_out(i_spi_out), .o_spi_oe(i_spi_oe),
		.o_scl_low(i_scl_low), .o_sda_low(i_sda_low), .o_txd(i_txd),
		.o_clk_out(i_clk_out), .o_tdo(i_tdo), .o_tdo_oe(i_tdo_oe));

	// Expected {oe, out} of pad k at the next edge
	function automatic logic [1:0] exp_pad(input int k);
		logic [1:0] s2;
		logic [1:0] s4;
		s2 = sel_m[1:0];
		s4 = sel_m[3:2];
		if (!BOND[k] || k > 27) return 2'h0;
		if (!en_m[k]) return (k == 14 && i_external_clock_input_en) ? 2'h0 : {i_gpio_oe[k], i_gpio_out[k]};
		case (k)
			0, 1, 2, 3: return {1'b1, i_pwm_out[k]};
			4: return s2 == 2'h2 ? {i_tmr_oe[2], i_tmr_out[2]} : s2 == 2'h1 ? 2'h0 : {1'b1, i_pwm_out[4]};
			5: return s4 == 2'h2 ? {i_tmr_oe[3], i_tmr_out[3]} : s4 == 2'h1 ? 2'h0 : {1'b1, i_pwm_out[5]};
			8: return sel_m[4] ? {i_scl_low, 1'b0} : {i_spi_oe[0], i_spi_out[0]};
			9: return sel_m[5] ? {i_sda_low, 1'b0} : {i_spi_oe[1], i_spi_out[1]};
			10: return sel_m[6] ? {i_tmr_oe[2], i_tmr_out[2]} : {i_spi_oe[2], i_spi_out[2]};
			11: return sel_m[7] ? {i_tmr_oe[3], i_tmr_out[3]} : {i_spi_oe[3], i_spi_out[3]};
			12: return sel_m[8] ? {1'b1, i_clk_out} : {i_tmr_oe[0], i_tmr_out[0]};
			13: return sel_m[9] ? 2'h0 : {i_tmr_oe[1], i_tmr_out[1]};
			14: return (sel_m[10] && !i_external_clock_input_en) ? {i_sda_low, 1'b0} : 2'h0;
			15: return sel_m[11] ? {i_scl_low, 1'b0} : {1'b1, i_txd};
			25: return {i_tdo_oe, i_tdo};
			default: return 2'h0;
		endcase
	endfunction

	// Expected peripheral-side inputs from the pad sample ein and the current config
	function automatic logic [18:0] exp_in();
		logic [3:0] f;
		logic [3:0] t;
		logic [3:0] s;
		logic       scl;
		logic       sda;
		logic       rx;
		logic       b6;
		f = {en_m[13] & sel_m[9] & ein[13], en_m[5] & (sel_m[3:2] == 2'h1) & ein[5],
			en_m[4] & (sel_m[1:0] == 2'h1) & ein[4], en_m[6] & ein[6]};
		t[0] = en_m[12] & ~sel_m[8] & ein[12];
		t[1] = en_m[13] & ~sel_m[9] & ein[13];
		t[2] = (en_m[4] && sel_m[1:0] == 2'h2) ? ein[4] : en_m[10] & sel_m[6] & ein[10];
		t[3] = (en_m[5] && sel_m[3:2] == 2'h2) ? ein[5] : en_m[11] & sel_m[7] & ein[11];
		for (int i = 0; i < 4; i++) s[i] = (en_m[8 + i] && !sel_m[4 + i]) ? ein[8 + i] : (i == 1);
		b6 = en_m[14] && !i_external_clock_input_en;
		scl = (!(en_m[8] && sel_m[4]) || ein[8]) && (!(en_m[15] && sel_m[11]) || ein[15]);
		sda = (!(en_m[9] && sel_m[5]) || ein[9]) && (!(b6 && sel_m[10]) || ein[14]);
		rx = (b6 && !sel_m[10]) ? ein[14] : 1'b1;
		return {f, t, s, scl, sda, rx, en_m[7] ? ein[7] : 1'b1, en_m[24] ? ein[24] : 1'b1,
			en_m[26] & ein[26], en_m[27] ? ein[27] : 1'b1};
	endfunction

	// Mode 0 random writes, 1 all ones to every store, 2 all zeros
	task automatic step(input int mode);
		i_gpio_out = $urandom;
		i_gpio_oe = $urandom;
		i_external_clock_input_en = ($urandom % 4) == 0;
		i_peren_we = (mode != 0) ? 4'hF : ($urandom % 3 == 0) ? 4'($urandom) : 4'h0;
		i_peren_wdata = (mode == 1) ? 8'hFF : (mode == 2) ? 8'h00 : 8'($urandom);
		i_sel_we = (mode != 0) || ($urandom % 3 == 0);
		i_sel_wdata = (mode == 1) ? 16'hFFFF : (mode == 2) ? 16'h0000 : 16'($urandom);
		#1;
		for (int k = 0; k < 32; k++) {eoe[k], eout[k]} = exp_pad(k);
		ein = i_pad_in & BOND;
		eclk = i_external_clock_input_en & i_pad_in[14];
		for (int p = 0; p < 4; p++) if (i_peren_we[p]) en_m[p*8 +: 8] = i_peren_wdata;
		en_m = en_m & `PMX_PEREN_MASK;
		if (i_sel_we) sel_m = i_sel_wdata;
		@(posedge i_mclk);
		#1;
		`CHK(o_pad_oe, eoe)
		`CHK(o_pad_out & eoe, eout & eoe)
		`CHK(o_gpio_in, ein)
		`CHK(o_ext_clk, eclk)
		`CHK(o_peren, en_m)
		`CHK(o_sel, sel_m)
		`CHK(o_analog_en, en_m[23:16])
		ei = exp_in();
		`CHK(o_fault_in, ei[18:15])
		`CHK(o_tmr_in, ei[14:11])
		`CHK(o_spi_in, ei[10:7])
		`CHK({o_scl_in, o_sda_in}, ei[6:5])
		`CHK(o_rxd, ei[4])
		`CHK({o_reset_pin_n, o_tdi, o_tck, o_tms}, ei[3:0])
	endtask

	task automatic do_reset;
		i_srst = 1'b1;
		repeat (16) @(posedge i_mclk);
		#1;
		i_srst = 1'b0;
		en_m = `PMX_PEREN_RST;
		sel_m = `PMX_SEL_RST;
		`CHK(o_peren, 32'h0FFF0080)
		`CHK(o_sel, 16'h0000)
		`CHK(o_pad_oe, 32'h0)
	endtask

	task automatic final_report;
		if (err_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Whole run is about 2035 cycles
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			final_report();
		end
	end

	initial begin
		void'($urandom(42));
		do_reset();
		step(1);
		step(2);
		repeat (1500) step(0);
		do_reset();
		step(1);
		repeat (500) step(0);
		final_report();
	end
endmodule // testbench
